// file: src/fcr_pkg.sv
`default_nettype none
package fcr_pkg;
  // Fault slots
  localparam int NF = 10;
  localparam int F_UNDER_B = 0;
  localparam int F_EXC_A = 1;
  localparam int F_EXC_B = 2;
  localparam int F_NB_NEUT = 3;
  localparam int F_NB_TRACK = 4;
  localparam int F_NB_REP = 5;
  localparam int F_VREF = 6;
  localparam int F_NODE = 7;
  localparam int F_EE = 8;
  localparam int F_OVF = 9;
  localparam logic [NF-1:0][15:0] CODE = {16'h6208, 16'h5535, 16'h8004,
    16'h3111, 16'h830b, 16'h830a, 16'h8309, 16'hff18, 16'hff17, 16'hff1a};
  localparam logic [NF-1:0][7:0] ERRREG = {8'h81, 8'h81, 8'h81, 8'h05,
    8'h81, 8'h81, 8'h81, 8'h81, 8'h81, 8'h81};
  localparam logic [NF-1:0] FILTERED = 10'h078;
  localparam logic [NF-1:0] APP_CLR = 10'h07f;
  // Object dictionary
  localparam logic [15:0] OD_INHIBIT = 16'h1015;
  localparam logic [15:0] INH_RESET = 16'h00c8;
  localparam logic [15:0] INH_MIN = 16'h0064;
  localparam logic [15:0] INH_MAX = 16'h00c8;
  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int INH_UNIT_US = 100;
  localparam int INH_UNIT_CYC = INH_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int FILT_US = 10_000;
  localparam int FILT_CYC_DEF = FILT_US * (CLK_HZ / 1_000_000);
  // Thresholds
  localparam logic [9:0] TRAVEL_MIN = 10'h047;
  localparam logic [9:0] TRAVEL_MAX = 10'h0d6;
  localparam logic [11:0] VREF_LO_MV = 12'h8ca;
  localparam logic [11:0] VREF_HI_MV = 12'habe;
  localparam logic [15:0] EE_BOOT_END = 16'h01f4;
  localparam int GRP_SHIFT = 4;
  localparam logic [6:0] NODE_MIN = 7'h01;
endpackage
`default_nettype wire

// file: src/fcr_reporter.sv
// How it works
// R1 - Low B-port self-test travel raises 0xFF1A
// R2 - Neighbour leaves neutral: filtered 0x8309
// R3 - Neighbour misses set point: filtered 0x830A
// R4 - Neighbour CAN/analogue mismatch: filtered 0x830B
// R5 - Reference outside 2.25-2.75 V: filtered 0x3111
// R6 - Neighbour in other group: 0x8004, halt
// R7 - Equal or invalid ids: same fault
// R8 - Id fault holds until ids valid
// R9 - Refuse EEPROM access below address 500
// R10 - Address fault 0x5535, cleared only by power-up
// R11 - Buffer overflow 0x6208, cleared only by power-up
// R12 - Application reset clears self-test, neighbour, reference faults
// R13 - Inhibit default 0xC8, accepts 0x64-0xC8
// R14 - Excess self-test travel raises critical fault
// R15 - Emergencies spaced by inhibit; pending queued
// R16 - Filtered faults debounced; unfiltered report immediately
`timescale 1ns/1ps
`default_nettype none
module fcr_reporter #(
  parameter int DEPTH = 8,
  parameter int FILT_CYC = fcr_pkg::FILT_CYC_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic app_reset,
  // Self test measurement
  input wire logic safety_self_test_sequence,
  input wire logic st_port_b,
  input wire logic st_done,
  input wire logic [9:0] st_travel,
  // Neighbour supervision
  input wire logic nb_out_of_neutral,
  input wire logic nb_setpoint_miss,
  input wire logic nb_report_mismatch,
  // Supplies and configuration
  input wire logic [11:0] vref_mv,
  input wire logic [6:0] own_node_id,
  input wire logic [6:0] nb_node_id,
  // EEPROM guard
  input wire logic ee_req,
  input wire logic [15:0] ee_addr,
  output logic ee_grant,
  // Object dictionary access
  input wire logic od_wr,
  input wire logic [15:0] od_index,
  input wire logic [15:0] od_wdata,
  output logic [15:0] od_rdata,
  // Emergency output
  output logic emcy_valid,
  output logic [15:0] emcy_code,
  output logic [7:0] emcy_errreg,
  output logic [fcr_pkg::NF-1:0] fault_active,
  output logic halt
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] FC_MAX = CW'(FILT_CYC - 1);
  localparam logic [11:0] TICK_MAX = 12'(fcr_pkg::INH_UNIT_CYC - 1);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [fcr_pkg::NF-1:0] lat;
    logic [fcr_pkg::NF-1:0] rep;
    logic [3:0][CW-1:0] fcnt;
    logic [DEPTH-1:0][3:0] q;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [11:0] tick;
    logic [15:0] inh_left;
    logic [15:0] inh_time;
    logic emcy_v;
    logic [15:0] emcy_code;
    logic [7:0] emcy_er;
    logic [15:0] rdata;
    logic ee_grant;
    logic halt;
  } fcr_state_s;

  fcr_state_s s_q;
  fcr_state_s s_d;

  logic [fcr_pkg::NF-1:0] det;
  logic [fcr_pkg::NF-1:0] fset;
  logic [fcr_pkg::NF-1:0] set;
  logic node_bad;
  logic ee_bad;
  logic st_meas;

  assign st_meas = st_done && safety_self_test_sequence;
  assign ee_bad = ee_req && (ee_addr < fcr_pkg::EE_BOOT_END); // R9
  // Group is the upper id bits; zero is not a usable node id
  assign node_bad = (own_node_id < fcr_pkg::NODE_MIN) || (nb_node_id < fcr_pkg::NODE_MIN)
    || (own_node_id == nb_node_id)
    || ((own_node_id >> fcr_pkg::GRP_SHIFT) != (nb_node_id >> fcr_pkg::GRP_SHIFT)); // R6 R7

  always_comb begin
    det = '0;
    det[fcr_pkg::F_UNDER_B] = st_meas && st_port_b && (st_travel < fcr_pkg::TRAVEL_MIN); // R1
    det[fcr_pkg::F_EXC_A] = st_meas && !st_port_b && (st_travel > fcr_pkg::TRAVEL_MAX); // R14
    det[fcr_pkg::F_EXC_B] = st_meas && st_port_b && (st_travel > fcr_pkg::TRAVEL_MAX); // R14
    det[fcr_pkg::F_NB_NEUT] = nb_out_of_neutral; // R2
    det[fcr_pkg::F_NB_TRACK] = nb_setpoint_miss; // R3
    det[fcr_pkg::F_NB_REP] = nb_report_mismatch; // R4
    det[fcr_pkg::F_VREF] = (vref_mv < fcr_pkg::VREF_LO_MV) || (vref_mv > fcr_pkg::VREF_HI_MV); // R5
    det[fcr_pkg::F_NODE] = node_bad;
    det[fcr_pkg::F_EE] = ee_bad; // R10
  end

  always_comb begin
    logic pv;
    logic [3:0] pick;
    logic tk;
    pv = 1'b0;
    pick = '0;
    tk = (s_q.tick == TICK_MAX);
    s_d = s_q;
    s_d.emcy_v = 1'b0;
    fset = '0;
    // Inhibit time base, one tick per 100 us
    s_d.tick = tk ? '0 : s_q.tick + 12'h001;
    if (tk && (s_q.inh_left != '0)) begin
      s_d.inh_left = s_q.inh_left - 16'h0001; // R15
    end
    // Debounce: condition must hold FILT_CYC cycles in a row
    for (int i = 0; i < 4; i++) begin
      if (det[fcr_pkg::F_NB_NEUT + i]) begin
        if (s_q.fcnt[i] == FC_MAX) begin
          fset[fcr_pkg::F_NB_NEUT + i] = 1'b1; // R16
        end else begin
          s_d.fcnt[i] = s_q.fcnt[i] + 1'b1;
        end
      end else begin
        s_d.fcnt[i] = '0;
      end
    end
    set = (det & ~fcr_pkg::FILTERED) | fset; // R16
    // New set wins over an application reset in the same cycle
    s_d.lat = (s_q.lat & ~(app_reset ? fcr_pkg::APP_CLR : '0)) | set; // R12
    // Id fault follows the configuration, untouched by application reset
    s_d.lat[fcr_pkg::F_NODE] = node_bad; // R8
    s_d.rep = s_q.rep | (set & ~s_q.lat);
    s_d.halt = node_bad; // R6
    s_d.ee_grant = ee_req && !ee_bad; // R9
    // Queue one newly raised fault per cycle, lowest slot first
    for (int i = 0; i < fcr_pkg::NF - 1; i++) begin
      if (!pv && s_q.rep[i]) begin
        pv = 1'b1;
        pick = 4'(i);
      end
    end
    if (pv) begin
      s_d.rep[pick] = 1'b0;
      if (s_q.cnt == FULL) begin
        // Lost entry becomes the overflow fault
        s_d.lat[fcr_pkg::F_OVF] = 1'b1; // R11
        s_d.rep[fcr_pkg::F_OVF] = s_d.rep[fcr_pkg::F_OVF] | ~s_q.lat[fcr_pkg::F_OVF];
      end else begin
        s_d.q[s_q.wp] = pick; // R15
        s_d.wp = s_q.wp + 1'b1;
        s_d.cnt = s_d.cnt + 1'b1;
      end
    end
    // Emit when the inhibit window has run out; overflow jumps the queue
    if (s_q.inh_left == '0) begin
      if (s_q.rep[fcr_pkg::F_OVF]) begin
        s_d.rep[fcr_pkg::F_OVF] = 1'b0;
        s_d.emcy_v = 1'b1;
        s_d.emcy_code = fcr_pkg::CODE[fcr_pkg::F_OVF];
        s_d.emcy_er = fcr_pkg::ERRREG[fcr_pkg::F_OVF];
        s_d.inh_left = s_q.inh_time; // R15
        s_d.tick = '0;
      end else if (s_q.cnt != '0) begin
        s_d.emcy_v = 1'b1;
        s_d.emcy_code = fcr_pkg::CODE[s_q.q[s_q.rp]];
        s_d.emcy_er = fcr_pkg::ERRREG[s_q.q[s_q.rp]];
        s_d.rp = s_q.rp + 1'b1;
        s_d.cnt = s_d.cnt - 1'b1;
        s_d.inh_left = s_q.inh_time; // R15
        s_d.tick = '0;
      end
    end
    // Out-of-range inhibit writes are dropped, old value stays
    if (od_wr && (od_index == fcr_pkg::OD_INHIBIT) && (od_wdata >= fcr_pkg::INH_MIN)
        && (od_wdata <= fcr_pkg::INH_MAX)) begin
      s_d.inh_time = od_wdata; // R13
    end
    s_d.rdata = (od_index == fcr_pkg::OD_INHIBIT) ? s_q.inh_time : '0;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.inh_time <= fcr_pkg::INH_RESET; // R13
    end else begin
      s_q <= s_d;
    end
  end

  assign ee_grant = s_q.ee_grant;
  assign od_rdata = s_q.rdata;
  assign emcy_valid = s_q.emcy_v;
  assign emcy_code = s_q.emcy_code;
  assign emcy_errreg = s_q.emcy_er;
  assign fault_active = s_q.lat;
  assign halt = s_q.halt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_under_b_raise: assert property (st_meas && st_port_b && st_travel < 10'h047 |=> // R1
    fault_active[0] && (s_q.rep[0] || $past(fault_active[0]))) else $error("low B travel not raised");
  a_excess_raise: assert property (st_meas && st_travel > 10'h0d6 |=> // R14
    ($past(st_port_b) && fault_active[2]) || (!$past(st_port_b) && fault_active[1]))
    else $error("excess travel not raised");
  a_filter_wait: assert property ($rose(nb_out_of_neutral) && !fault_active[3] |=> // R16
    !fault_active[3]) else $error("filtered fault raised at once");
  a_vref_quiet: assert property (vref_mv >= 12'h8ca && vref_mv <= 12'habe && !fault_active[6] // R5
    |=> !fault_active[6]) else $error("reference fault without cause");
  a_node_follow: assert property (1'b1 |=> halt == $past(node_bad) // R8
    && fault_active[7] == $past(node_bad)) else $error("id fault does not follow config");
  a_ee_reject: assert property (ee_bad |=> !ee_grant && fault_active[8]) // R9
    else $error("boot region access granted");
  a_ee_sticky: assert property (fault_active[8] |=> fault_active[8]) // R10
    else $error("address fault cleared");
  a_ovf_sticky: assert property (fault_active[9] |=> fault_active[9]) // R11
    else $error("overflow fault cleared");
  a_inh_space: assert property (emcy_valid |-> s_q.inh_left == $past(s_q.inh_time) // R15
    ##1 !emcy_valid [*2]) else $error("emergency inside inhibit window");
  a_inh_range: assert property (od_wr && od_index == 16'h1015 && (od_wdata < 16'h0064 // R13
    || od_wdata > 16'h00c8) |=> $stable(s_q.inh_time)) else $error("bad inhibit accepted");

  // Whole window is far too long to run, so the countdown is checked step by step
  a_inh_block: assert property (s_q.inh_left != 16'h0000 // R15
    |=> !emcy_valid)
    else $error("emergency while inhibit running");
  a_inh_hold: assert property (s_q.inh_left != 16'h0000 && s_q.tick != TICK_MAX // R15
    |=> s_q.inh_left == $past(s_q.inh_left))
    else $error("inhibit moved between ticks");
  a_inh_step: assert property (s_q.inh_left != 16'h0000 && s_q.tick == TICK_MAX // R15
    |=> s_q.inh_left == $past(s_q.inh_left) - 16'h0001)
    else $error("inhibit missed a tick");
  a_tick_wrap: assert property (s_q.tick == TICK_MAX // R15
    |=> s_q.tick == 12'h000)
    else $error("tick base overran");
  a_queue_bound: assert property (s_q.cnt <= FULL) // R15
    else $error("queue count past depth");
  a_ovf_raise: assert property (s_q.cnt == FULL && s_q.rep[fcr_pkg::NF-2:0] != '0 // R11
    |=> fault_active[fcr_pkg::F_OVF])
    else $error("lost entry without overflow");
  a_ovf_quiet: assert property (s_q.cnt != FULL && !fault_active[fcr_pkg::F_OVF] // R11
    |=> !fault_active[fcr_pkg::F_OVF])
    else $error("overflow without a full queue");
  a_errreg_pair: assert property (emcy_valid // R5
    |-> emcy_errreg == ((emcy_code == 16'h3111) ? 8'h05 : 8'h81))
    else $error("error register does not match code");

  // Self-test, id and EEPROM reporting
  a_travel_quiet: assert property (st_meas && st_travel >= fcr_pkg::TRAVEL_MIN // R1 R14
    && st_travel <= fcr_pkg::TRAVEL_MAX && fault_active[2:0] == 3'b000
    |=> fault_active[2:0] == 3'b000) else $error("travel in range raised a fault");
  a_port_a_low: assert property (st_meas && !st_port_b && !fault_active[0] // R1
    |=> !fault_active[0])
    else $error("A port raised the B travel fault");
  a_node_report: assert property (node_bad && !fault_active[fcr_pkg::F_NODE] // R6
    |=> s_q.rep[fcr_pkg::F_NODE])
    else $error("id fault not queued");
  a_ee_report: assert property (ee_bad && !fault_active[fcr_pkg::F_EE] // R10
    |=> s_q.rep[fcr_pkg::F_EE])
    else $error("address fault not queued");
  a_ee_grant: assert property (ee_req && ee_addr >= fcr_pkg::EE_BOOT_END // R9
    |=> ee_grant)
    else $error("valid EEPROM access refused");
  a_grant_idle: assert property (!ee_req // R9
    |=> !ee_grant)
    else $error("grant without request");

  // Debounce, clearing and register view
  a_filter_raise: assert property (det[fcr_pkg::F_NB_NEUT] && s_q.fcnt[0] == FC_MAX // R16
    |=> fault_active[fcr_pkg::F_NB_NEUT])
    else $error("debounced fault not raised");
  a_vref_raise: assert property (det[fcr_pkg::F_VREF] && s_q.fcnt[3] == FC_MAX // R5
    |=> fault_active[fcr_pkg::F_VREF])
    else $error("reference fault not raised");
  a_app_clear: assert property (app_reset && (set & fcr_pkg::APP_CLR) == '0 // R12
    |=> (fault_active & fcr_pkg::APP_CLR) == '0)
    else $error("application reset left a fault");
  a_inh_accept: assert property (od_wr && od_index == fcr_pkg::OD_INHIBIT // R13
    && od_wdata >= fcr_pkg::INH_MIN && od_wdata <= fcr_pkg::INH_MAX
    |=> s_q.inh_time == $past(od_wdata)) else $error("valid inhibit not stored");
  a_rdata_view: assert property (od_index == fcr_pkg::OD_INHIBIT // R13
    |=> od_rdata == $past(s_q.inh_time))
    else $error("inhibit read wrong");
  a_rdata_idle: assert property (od_index != fcr_pkg::OD_INHIBIT // R13
    |=> od_rdata == 16'h0000)
    else $error("read data outside register");

  c_emcy_sent: cover property (emcy_valid);
  c_neigh_report: cover property (emcy_valid && emcy_code == 16'h8309);
  c_overflow: cover property ($rose(fault_active[9]));
  c_node_halt: cover property ($rose(halt));
  c_app_clear: cover property (app_reset && fault_active[fcr_pkg::F_VREF]);
endmodule
`default_nettype wire

// file: testbench/fcr_net_master.sv
`timescale 1ns/1ps
`default_nettype none
module fcr_net_master (
  // Clock
  input wire logic clock,
  // Emergency stream from the device
  input wire logic emcy_valid,
  input wire logic [15:0] emcy_code,
  input wire logic [7:0] emcy_errreg,
  // Application reset request
  input wire logic reset_cmd,
  output logic app_reset
);
  logic [23:0] rx_q[$];
  // Register and code are logged together so arrival order is kept
  always @(posedge clock) begin
    if (emcy_valid === 1'b1) begin
      rx_q.push_back({emcy_errreg, emcy_code});
    end
  end
  assign app_reset = reset_cmd;
endmodule
`default_nettype wire

// file: testbench/tb_fault_code_reporter.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fault_code_reporter;
  logic clock = 0, nrst = 0, reset_cmd = 0, app_reset, sst = 0, st_port_b = 0, st_done = 0;
  logic [9:0] st_travel = 0;
  logic [2:0] nb = 0;
  logic [11:0] vref_mv = 12'd2500;
  logic [6:0] own_node_id = 7'h11, nb_node_id = 7'h12;
  logic ee_req = 0, ee_grant, od_wr = 0, emcy_valid, halt;
  logic [15:0] ee_addr = 0, od_index = 16'h1015, od_wdata = 0, od_rdata, emcy_code;
  logic [7:0] emcy_errreg;
  logic [fcr_pkg::NF-1:0] fault_active;
  logic [23:0] exp_t [10] = '{24'h81ff1a, 24'h81ff17, 24'h81ff18, 24'h818309, 24'h81830a,
    24'h81830b, 24'h053111, 24'h818004, 24'h815535, 24'h816208};
  int num_errors = 0, checked = 0, cycles = 0, inh = 200;
  always #12.5 clock = ~clock;
  fcr_reporter #(.FILT_CYC(4)) DUT (.clock(clock), .nrst(nrst), .app_reset(app_reset),
    .safety_self_test_sequence(sst), .st_port_b(st_port_b), .st_done(st_done), .st_travel(st_travel),
    .nb_out_of_neutral(nb[0]), .nb_setpoint_miss(nb[1]), .nb_report_mismatch(nb[2]), .vref_mv(vref_mv),
    .own_node_id(own_node_id), .nb_node_id(nb_node_id), .ee_req(ee_req), .ee_addr(ee_addr),
    .ee_grant(ee_grant), .od_wr(od_wr), .od_index(od_index), .od_wdata(od_wdata), .od_rdata(od_rdata),
    .emcy_valid(emcy_valid), .emcy_code(emcy_code), .emcy_errreg(emcy_errreg),
    .fault_active(fault_active), .halt(halt));
  fcr_net_master master (.clock(clock), .emcy_valid(emcy_valid), .emcy_code(emcy_code),
    .emcy_errreg(emcy_errreg), .reset_cmd(reset_cmd), .app_reset(app_reset));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic rst;
    nrst = 0;
    cyc(2);
    nrst = 1;
  endtask
  // Bounded wait for the next emergency, then compare with the table
  task automatic msg(input int s);
    for (int i = 0; i < 20 && master.rx_q.size() == 0; i++) cyc(1);
    chk("emcy", (master.rx_q.size() != 0) ? master.rx_q.pop_front() : 24'h0, exp_t[s]);
    chk("fault", fault_active[s], 1);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results;
    end
  end
  initial begin
    void'($urandom(32'hbbea));
    cyc(10);
    nrst = 1;
    cyc(2);
    chk("inh_rst", od_rdata, 16'h00c8);
    foreach (exp_t[k]) begin
      od_wdata = (k % 2) ? 16'h0064 + 16'($urandom % 101) : 16'h0063 + 16'(($urandom % 2) * 102);
      if (od_wdata >= 100 && od_wdata <= 200) inh = od_wdata;
      od_wr = 1;
      cyc(1);
      od_wr = 0;
      cyc(2);
      chk("inh", od_rdata, 16'(inh));
    end
    for (int s = 0; s < 3; s++) begin
      rst;
      sst = 1;
      st_port_b = (s != 1);
      st_travel = s ? 10'(215 + $urandom % 300) : 10'($urandom % 71);
      st_done = 1;
      cyc(1);
      st_done = 0;
      sst = 0;
      msg(s);
    end
    // Travel exactly at the minimum must not count as low
    rst;
    {sst, st_port_b, st_done, st_travel} = {3'b111, 10'd71};
    cyc(1);
    {sst, st_done} = 0;
    cyc(4);
    chk("edge71", fault_active, 0);
    for (int s = 3; s < 7; s++) begin
      rst;
      if (s < 6) nb[s-3] = 1;
      else vref_mv = ($urandom % 2) ? 12'd2751 : 12'd2249;
      cyc(3);
      chk("debounce", fault_active[s], 0);
      msg(s);
      {nb, vref_mv} = {3'b0, 12'd2500};
      {reset_cmd, ee_req, ee_addr} = {2'b11, 16'd499};
      cyc(1);
      {reset_cmd, ee_req} = 0;
      cyc(2);
      chk("app_clr", fault_active[s], 0);
      chk("ee_keep", fault_active[8], 1);
      chk("spacing", master.rx_q.size(), 0);
    end
    rst;
    {ee_req, ee_addr} = {1'b1, 16'd500};
    cyc(1);
    chk("grant", {ee_grant, fault_active[8]}, 2'b10);
    ee_addr = 16'd499;
    cyc(1);
    ee_req = 0;
    chk("refuse", ee_grant, 0);
    msg(8);
    rst;
    nb_node_id = own_node_id;
    msg(7);
    reset_cmd = 1;
    cyc(2);
    reset_cmd = 0;
    chk("id_hold", {fault_active[7], halt}, 2'b11);
    nb_node_id = 7'h21;
    cyc(3);
    chk("group", {fault_active[7], halt}, 2'b11);
    for (int i = 0; i < 20; i++) begin
      nb_node_id = (i % 2) ? 7'h00 : 7'h12;
      cyc(3);
    end
    nb_node_id = 7'h12;
    cyc(3);
    chk("id_ok", {fault_active[7], halt}, 2'b00);
    chk("ovf", fault_active[9], 1);
    results;
  end
endmodule
`default_nettype wire
